// ### src/tcc_timer_capture_compare.v
// Purpose: capture/compare logic around a free-running 16-bit timer
// Assumes: one clock; machine cycle of twelve clocks; Wishbone slave
// Notes: timer steps once per machine cycle
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
// Notes on behaviour
// - four 16-bit capture registers load timer on pin edge, request interrupt
// - each capture input selects rising, falling or both edges
// - inputs sampled at state1_phase1; timer latched at end of that cycle
// - capture flags work as extra external interrupts without using values
// - each timer increment compares new value against three compare registers
// - compare flag sets at end of the cycle following the match
// - compare 0 match drives high port bits 0-5 enabled in set mask
// - compare 1 match clears port bits 0-7 enabled in reset mask
// - compare 2 match toggles port bits 6 and 7
// - capture/compare requests seen in the cycle after the flag sets
// - overflow flags set at state_six; seen by interrupts at the end of that same cycle
// - priority bit one means high priority, zero low
// - priority bits: 7 overflow, 6 cmp2, 4 cmp0, 3..0 captures
module tcc_timer_capture_compare (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  // Capture pins
  input wire [3:0] capture_in_i,
  // Output port and interrupts
  output reg [7:0] port_o,
  output reg irq_o,
  output reg irq_high_o,
  output reg irq_low_o
);
  reg [3:0] phase;
  reg [15:0] main_timer;
  reg [15:0] capture_reg [0:3];
  reg [15:0] compare_reg_0;
  reg [15:0] compare_reg_1;
  reg [15:0] compare_reg_2;
  reg [7:0] capture_edge_control;
  reg [7:0] set_enable_mask;
  reg [7:0] reset_enable_mask;
  reg [7:0] timer_interrupt_priority;
  reg [`TCC_NFLAGS-1:0] timer_irq_flags;
  reg [`TCC_NFLAGS-1:0] irq_enable;
  reg [`TCC_NFLAGS-1:0] flags_seen;
  reg [3:0] cap_pend;
  reg [2:0] match_pend;
  reg [2:0] match_now;
  reg [`TCC_NFLAGS-1:0] next_set;
  reg [`TCC_NFLAGS-1:0] next_clr;
  reg [7:0] next_prio_hi;
  reg [`TCC_NFLAGS-1:0] irq_req;
  reg [7:0] next_port;
  wire [3:0] cap_hit;
  wire cyc_end;
  wire state1_phase1;
  wire s6;
  wire wb_req;
  wire wr;
  wire [15:0] timer_next;
  integer i;
  genvar g;

  // Byte-lane merge, used by all writable registers except the flags and enable bits 9:8
  function [7:0] lane;
    input [7:0] old;
    input [7:0] nw;
    input en;
    begin
      lane = en ? nw : old;
    end
  endfunction

  assign cyc_end = (phase == `TCC_CYC_LAST);
  assign state1_phase1 = (phase == `TCC_PH_STATE1_PHASE1);
  assign s6 = (phase == `TCC_PH_S6);
  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign wr = wb_req & we_i;
  assign err_o = 1'b0;
  assign timer_next = main_timer + 16'h0001;

  // One edge detector per capture pin
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_cap
      tcc_edge_detect u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(capture_in_i[g]),
        .sample_i(state1_phase1),
        .mode_i(capture_edge_control[2*g+1 -: 2]),
        .hit_o(cap_hit[g])
      );
    end
  endgenerate

  // Machine-cycle state and phase counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 4'h0;
    end else if (cyc_end) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // Timer and capture latching at the end of the cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      main_timer <= `TCC_ZERO16;
      cap_pend <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        capture_reg[i] <= `TCC_ZERO16;
      end
    end else begin
      cap_pend <= cyc_end ? 4'h0 : (cap_pend | cap_hit);
      for (i = 0; i < 4; i = i + 1) begin
        if (cyc_end && (cap_pend[i] || cap_hit[i])) begin
          capture_reg[i] <= main_timer;
        end
      end
      if (wr && adr_i == `TCC_ADR_TIMER) begin
        main_timer <= {lane(main_timer[15:8], dat_i[15:8], sel_i[1]),
                       lane(main_timer[7:0], dat_i[7:0], sel_i[0])};
      end else if (cyc_end) begin
        main_timer <= timer_next;
      end
    end
  end

  // Compare the new timer value; pending match acted on next cycle end
  always @* begin
    match_now[0] = (timer_next == compare_reg_0);
    match_now[1] = (timer_next == compare_reg_1);
    match_now[2] = (timer_next == compare_reg_2);
  end

  // Flag sources: set wins over software clear
  always @* begin
    next_set = {`TCC_NFLAGS{1'b0}};
    if (cyc_end) begin
      next_set[3:0] = cap_pend | cap_hit;
      next_set[`TCC_F_CMP0] = match_pend[0];
      next_set[`TCC_F_CMP1] = match_pend[1];
      next_set[`TCC_F_CMP2] = match_pend[2];
    end
    if (s6 && main_timer == `TCC_ONES16) begin
      next_set[`TCC_F_WOV] = 1'b1;
    end
    if (s6 && main_timer[7:0] == `TCC_ONES8) begin
      next_set[`TCC_F_BOV] = 1'b1;
    end
    next_clr = {`TCC_NFLAGS{1'b0}};
    if (wr && adr_i == `TCC_ADR_FLAGS) begin
      next_clr = ~dat_i[`TCC_NFLAGS-1:0] &
                 {{2{sel_i[1]}}, {8{sel_i[0]}}};
    end
    if (wr && adr_i == `TCC_ADR_ICLR) begin
      next_clr = next_clr | (dat_i[`TCC_NFLAGS-1:0] & {{2{sel_i[1]}}, {8{sel_i[0]}}});
    end
  end

  // Port output next value from the pending match
  always @* begin
    next_port = port_o;
    if (cyc_end && match_pend[0]) begin
      next_port = next_port | (set_enable_mask & `TCC_SET_MASK);
    end
    if (cyc_end && match_pend[1]) begin
      next_port = next_port & ~reset_enable_mask;
    end
    if (cyc_end && match_pend[2]) begin
      next_port = next_port ^ ~`TCC_SET_MASK;
    end
  end

  // Priority split of pending requests; a cleared flag drops out at once
  always @* begin
    irq_req = flags_seen & irq_enable & timer_irq_flags;
    next_prio_hi = {irq_req[`TCC_F_WOV] | irq_req[`TCC_F_BOV],
                    irq_req[`TCC_F_CMP2], irq_req[`TCC_F_CMP1],
                    irq_req[`TCC_F_CMP0], irq_req[3:0]};
  end

  // Flags, match pipeline, control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_flags <= {`TCC_NFLAGS{1'b0}};
      flags_seen <= {`TCC_NFLAGS{1'b0}};
      match_pend <= 3'b000;
      compare_reg_0 <= `TCC_ZERO16;
      compare_reg_1 <= `TCC_ZERO16;
      compare_reg_2 <= `TCC_ZERO16;
      capture_edge_control <= `TCC_ZERO8;
      set_enable_mask <= `TCC_ZERO8;
      reset_enable_mask <= `TCC_ZERO8;
      timer_interrupt_priority <= `TCC_ZERO8;
      irq_enable <= {`TCC_NFLAGS{1'b0}};
      port_o <= `TCC_ZERO8;
    end else begin
      timer_irq_flags <= (timer_irq_flags & ~next_clr) | next_set;
      if (cyc_end) begin
        match_pend <= match_now;
        flags_seen <= timer_irq_flags;
      end
      port_o <= next_port;
      if (wr) begin
        case (adr_i)
          `TCC_ADR_CMP0: begin
            compare_reg_0 <= {lane(compare_reg_0[15:8], dat_i[15:8], sel_i[1]),
                              lane(compare_reg_0[7:0], dat_i[7:0], sel_i[0])};
          end
          `TCC_ADR_CMP1: begin
            compare_reg_1 <= {lane(compare_reg_1[15:8], dat_i[15:8], sel_i[1]),
                              lane(compare_reg_1[7:0], dat_i[7:0], sel_i[0])};
          end
          `TCC_ADR_CMP2: begin
            compare_reg_2 <= {lane(compare_reg_2[15:8], dat_i[15:8], sel_i[1]),
                              lane(compare_reg_2[7:0], dat_i[7:0], sel_i[0])};
          end
          `TCC_ADR_EDGE: begin
            capture_edge_control <= lane(capture_edge_control, dat_i[7:0], sel_i[0]);
          end
          `TCC_ADR_SETEN: begin
            set_enable_mask <= lane(set_enable_mask, dat_i[7:0], sel_i[0]);
          end
          `TCC_ADR_RSTEN: begin
            reset_enable_mask <= lane(reset_enable_mask, dat_i[7:0], sel_i[0]);
          end
          `TCC_ADR_PRIO: begin
            timer_interrupt_priority <= lane(timer_interrupt_priority, dat_i[7:0],
                                             sel_i[0]);
          end
          `TCC_ADR_IEN: begin
            // Only the two overflow enables live in the high lane
            if (sel_i[1]) begin
              irq_enable[`TCC_F_WOV:`TCC_F_BOV] <= dat_i[`TCC_F_WOV:`TCC_F_BOV];
            end
            irq_enable[7:0] <= lane(irq_enable[7:0], dat_i[7:0], sel_i[0]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Interrupt outputs, registered; priority from seen flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else begin
      // Flag bit 7 never sets, so irq_o always equals high or low
      irq_o <= |irq_req;
      irq_high_o <= |(next_prio_hi & timer_interrupt_priority);
      irq_low_o <= |(next_prio_hi & ~timer_interrupt_priority);
    end
  end

  // Wishbone read data and one-cycle ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          `TCC_ADR_TIMER: dat_o <= {16'h0000, main_timer};
          `TCC_ADR_CAP0: dat_o <= {16'h0000, capture_reg[0]};
          `TCC_ADR_CAP1: dat_o <= {16'h0000, capture_reg[1]};
          `TCC_ADR_CAP2: dat_o <= {16'h0000, capture_reg[2]};
          `TCC_ADR_CAP3: dat_o <= {16'h0000, capture_reg[3]};
          `TCC_ADR_CMP0: dat_o <= {16'h0000, compare_reg_0};
          `TCC_ADR_CMP1: dat_o <= {16'h0000, compare_reg_1};
          `TCC_ADR_CMP2: dat_o <= {16'h0000, compare_reg_2};
          `TCC_ADR_EDGE: dat_o <= {24'h00_0000, capture_edge_control};
          `TCC_ADR_FLAGS: dat_o <= {22'h0, timer_irq_flags};
          `TCC_ADR_SETEN: dat_o <= {24'h00_0000, set_enable_mask};
          `TCC_ADR_RSTEN: dat_o <= {24'h00_0000, reset_enable_mask};
          `TCC_ADR_PRIO: dat_o <= {24'h00_0000, timer_interrupt_priority};
          `TCC_ADR_PORT: dat_o <= {24'h00_0000, port_o};
          `TCC_ADR_IEN: dat_o <= {22'h0, irq_enable};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### src/tcc_consts.vh
// Purpose: constants for the timer capture/compare block
// Assumes: classic Wishbone, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
// Register byte offsets
`define TCC_ADR_TIMER 8'h00
`define TCC_ADR_CAP0 8'h04
`define TCC_ADR_CAP1 8'h08
`define TCC_ADR_CAP2 8'h0C
`define TCC_ADR_CAP3 8'h10
`define TCC_ADR_CMP0 8'h14
`define TCC_ADR_CMP1 8'h18
`define TCC_ADR_CMP2 8'h1C
`define TCC_ADR_EDGE 8'h20
`define TCC_ADR_FLAGS 8'h24
`define TCC_ADR_SETEN 8'h28
`define TCC_ADR_RSTEN 8'h2C
`define TCC_ADR_PRIO 8'h30
`define TCC_ADR_PORT 8'h34
`define TCC_ADR_IEN 8'h38
`define TCC_ADR_ICLR 8'h3C
// Machine cycle: six states of two phases
`define TCC_CYC_LEN 4'd12
`define TCC_CYC_LAST 4'd11
`define TCC_PH_STATE1_PHASE1 4'd0
`define TCC_PH_S6 4'd10
// Flag bit positions
`define TCC_F_CMP0 4
`define TCC_F_CMP1 5
`define TCC_F_CMP2 6
`define TCC_F_BOV 8
`define TCC_F_WOV 9
`define TCC_NFLAGS 10
// Edge select codes per input
`define TCC_EDGE_RISE 2'b01
`define TCC_EDGE_FALL 2'b10
`define TCC_EDGE_BOTH 2'b11
// Toggle outputs sit at port bits 6 and 7
`define TCC_SET_MASK 8'h3F
`define TCC_ZERO16 16'h0000
`define TCC_ZERO8 8'h00
`define TCC_ONES16 16'hFFFF
`define TCC_ONES8 8'hFF
`endif

// ### src/tcc_edge_detect.v
// Purpose: synchronise one capture pin and detect selected edges
// Assumes: sample pulse marks state1_phase1 of each machine cycle
// Notes: first flop only feeds the second
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_edge_detect (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Pin and control
  input wire pin_i,
  input wire sample_i,
  input wire [1:0] mode_i,
  // Result
  output reg hit_o
);
  reg meta;
  reg sync;
  reg last;

  // Two-flop synchroniser, sampled value kept per machine cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      hit_o <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      hit_o <= 1'b0;
      if (sample_i) begin
        last <= sync;
        // Edge seen between two state1_phase1 samples
        hit_o <= (mode_i[0] & sync & ~last) | (mode_i[1] & ~sync & last);
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tcc_chk.sv
// Purpose: port-level checks for the capture/compare block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design top after the module
`timescale 1ns/10ps
`default_nettype none
module tcc_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Port and interrupts
  input wire logic [7:0] port_o,
  input wire logic irq_o,
  input wire logic irq_high_o,
  input wire logic irq_low_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answers in exactly one cycle, as a pulse
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_err_low; !err_o; endproperty
  a_err_low: assert property (p_err_low) else $error("err raised");
  // Read data only moves with an answer
  property p_dat_hold; $changed(dat_o) |-> ack_o; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("dat moved");
  // Compare actions land only at machine cycle ends; check holds port changes at least nine clocks apart
  property p_port_gap; $changed(port_o) |=> $stable(port_o) [*8]; endproperty
  a_port_gap: assert property (p_port_gap) else $error("port early");
  property p_rst_quiet; $fell(rst_i) |-> port_o == 8'h00 && !irq_o && !ack_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not reset");
  property p_irq_split; irq_o == (irq_high_o || irq_low_o); endproperty
  a_irq_split: assert property (p_irq_split) else $error("irq split");
  c_port: cover property ($changed(port_o));
  c_high: cover property ($rose(irq_high_o));
  c_low: cover property ($rose(irq_low_o));
endmodule
bind tcc_timer_capture_compare tcc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .port_o(port_o),
  .irq_o(irq_o), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));
`default_nettype wire

// ### bench/tcc_pin_model.sv
// Purpose: far-side model driving the capture pins
// Assumes: levels requested by the bench
// Notes: LAG sets how slowly a requested edge reaches the pins
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model #(
  parameter int LAG = 3
) (
  // Clock
  input wire logic clk_i,
  // Requested levels
  input wire logic [3:0] want_i,
  // Capture pins
  output logic [3:0] pins_o
);
  logic [3:0] pipe [LAG];
  // Delay line, so edges arrive at any phase of the machine cycle
  always @(posedge clk_i) begin
    pipe[0] <= want_i;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign pins_o = pipe[LAG-1];
endmodule
`default_nettype wire

// ### bench/tcc_timer_capture_compare_bench.sv
// Purpose: self-checking bench for the capture/compare block
// Assumes: Wishbone answer after one cycle
// Notes: capture values checked in a window, phase is free
`timescale 1ns/10ps
`default_nettype none
`include "tcc_consts.vh"
module tcc_timer_capture_compare_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] want = 4'h0;
  wire logic [31:0] dat_o;
  wire logic ack_o, err_o, irq_o, irq_high_o, irq_low_o;
  wire logic [7:0] port_o;
  wire logic [3:0] pins;
  logic [31:0] rd;
  logic [15:0] t0;
  int errors = 0;
  int total_checks = 0;
  int n;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tcc_row_t;
  tcc_row_t rows [9];
  always #5 clk_i = ~clk_i;
  tcc_timer_capture_compare u_tcc_timer_capture_compare (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .capture_in_i(pins), .port_o(port_o),
    .irq_o(irq_o), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));
  tcc_pin_model #(.LAG(3)) u_tcc_pin_model (.clk_i(clk_i), .want_i(want), .pins_o(pins));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  // Classic cycle; hang on a missing ack ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      errors++;
      results();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic waitp(input logic [7:0] e);
    for (int k = 0; k < 400 && port_o !== e; k++) begin
      @(posedge clk_i);
    end
    chk(32'(port_o), 32'(e));
  endtask
  initial begin
    rows = '{'{`TCC_ADR_CMP0, 32'h0000_ABCD, 32'h0000_ABCD},
      '{`TCC_ADR_EDGE, 32'h0000_00FF, 32'h0000_00FF},
      '{`TCC_ADR_SETEN, 32'h0000_003F, 32'h0000_003F},
      '{`TCC_ADR_RSTEN, 32'h0000_00FF, 32'h0000_00FF},
      '{`TCC_ADR_PRIO, 32'h0000_00D5, 32'h0000_00D5},
      '{`TCC_ADR_IEN, 32'h0000_037F, 32'h0000_037F},
      '{`TCC_ADR_CAP0, 32'h0000_FFFF, 32'h0000_0000},
      '{`TCC_ADR_PORT, 32'h0000_00FF, 32'h0000_0000},
      '{8'h40, 32'h0000_1234, 32'h0000_0000}};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].a, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    // Set, reset, toggle in three successive matches
    wb(1'b1, `TCC_ADR_CMP0, 32'h0000_0102);
    wb(1'b1, `TCC_ADR_CMP1, 32'h0000_0104);
    wb(1'b1, `TCC_ADR_CMP2, 32'h0000_0106);
    wb(1'b1, `TCC_ADR_RSTEN, 32'h0000_000F);
    wb(1'b1, `TCC_ADR_PRIO, 32'h0000_0010);
    wb(1'b1, `TCC_ADR_IEN, 32'h0000_0030);
    wb(1'b1, `TCC_ADR_TIMER, 32'h0000_0100);
    waitp(8'h3F);
    waitp(8'h30);
    waitp(8'hF0);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0000_0070);
    chk(32'({irq_o, irq_high_o, irq_low_o}), 32'h7);
    wb(1'b1, `TCC_ADR_ICLR, 32'h0000_0010);
    for (n = 0; n < 40 && irq_high_o !== 1'b0; n++) begin
      @(posedge clk_i);
    end
    chk(32'({irq_o, irq_high_o, irq_low_o}), 32'h5);
    wb(1'b1, `TCC_ADR_FLAGS, 32'h0000_03BF);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0000_0020);
    // Low lane only: high byte of compare 1 must be kept
    sel_i <= 4'h1;
    wb(1'b1, `TCC_ADR_CMP1, 32'h0000_AA55);
    sel_i <= 4'h3;
    wb(1'b0, `TCC_ADR_CMP1, 32'h0);
    chk(rd, 32'h0000_0155);
    // Rise, fall, both, off on the four pins
    wb(1'b1, `TCC_ADR_FLAGS, 32'h0);
    wb(1'b1, `TCC_ADR_EDGE, 32'h0000_0039);
    wb(1'b0, `TCC_ADR_TIMER, 32'h0);
    t0 = rd[15:0];
    want <= 4'hF;
    repeat (60) @(posedge clk_i);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0000_0005);
    wb(1'b0, `TCC_ADR_CAP0, 32'h0);
    chk(32'((rd[15:0] - t0) < 16'h0006), 32'h1);
    want <= 4'h0;
    repeat (60) @(posedge clk_i);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0000_0007);
    // Wrap past all ones
    wb(1'b1, `TCC_ADR_FLAGS, 32'h0);
    wb(1'b1, `TCC_ADR_TIMER, 32'h0000_FFFE);
    repeat (40) @(posedge clk_i);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0000_0300);
    // Reset in mid-run
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({port_o, irq_o}), 32'h0);
    wb(1'b0, `TCC_ADR_FLAGS, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire
